// file: design/albc_lock_ctrl.sv
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module albc_lock_ctrl
   import albc_pkg::*;
#(
   parameter int LINE_BYTES = 64
) (
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    rst,
   // AHB-Lite register slave
   input  wire logic                    hsel,
   input  wire logic [ADDR_W-1:0]       haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic [31:0]                  hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   // Core side
   input  wire logic                    coreValid,
   input  wire albc_pkg::albc_req_t     coreReq,
   output logic                         coreReady,
   output albc_pkg::albc_rsp_t          coreRsp,
   input  wire logic                    wrValid,
   input  wire logic [63:0]             wrData,
   // Memory side
   output albc_pkg::albc_mem_t          memReq,
   input  wire logic                    memDone,
   input  wire logic [63:0]             memRdata,
   // Bus lock to system arbiter
   output logic                         busLock
);
   import albc_pkg::*;

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (LINE_BYTES < BUS_BYTES || (LINE_BYTES & (LINE_BYTES - 1)) != 0)
   begin : g_line_chk
      $error("LINE_BYTES must be a power of two of at least 8");
   end

   typedef enum logic [2:0] {
      S_IDLE   = 3'h0,
      S_LOCK   = 3'h1,
      S_READ   = 3'h2,
      S_MODIFY = 3'h3,
      S_WRITE  = 3'h4,
      S_DONE   = 3'h5
   } albc_state_t;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic logic [3:0] nBytes(input logic [1:0] s);
      return 4'(4'h1 << s);
   endfunction : nBytes

   // Whole access inside one cache line
   function automatic logic inLine(input logic [ADDR_W-1:0] a,
                                   input logic [1:0] s);
      logic [ADDR_W:0] ofs;
      ofs = {1'b0, a & ADDR_W'(LINE_BYTES - 1)};
      return (ofs + (ADDR_W+1)'(nBytes(s))) <= (ADDR_W+1)'(LINE_BYTES);
   endfunction : inLine

   // Access crosses an 8-byte data bus word
   function automatic logic spans(input logic [ADDR_W-1:0] a,
                                  input logic [1:0] s);
      return ({1'b0, a[2:0]} + nBytes(s)) > 4'(BUS_BYTES);
   endfunction : spans

   function automatic logic isAtomic(input logic [ADDR_W-1:0] a,
                                     input logic [1:0] s,
                                     input logic c);
      logic aligned;
      logic narrow;
      aligned = (a[2:0] & 3'(nBytes(s) - 4'h1)) == 3'h0;
      narrow  = ({2'b0, a[1:0]} + nBytes(s)) <= 4'(NARROW_BYTES);
      if (s == 2'h0)                  return 1'b1;
      if (aligned)                    return 1'b1;
      if (s == 2'h1 && !c && narrow)  return 1'b1;
      if (c && inLine(a, s))          return 1'b1;
      return 1'b0;
   endfunction : isAtomic

   // Instructions that may carry the atomic prefix
   function automatic logic prefixOk(input albc_cls_t k);
      case (k)
         IC_BIT_TEST, IC_XADD, IC_CMPXCHG, IC_SWAP,
         IC_INC, IC_DEC, IC_NOT, IC_NEG, IC_ALU2: return 1'b1;
         default:                                 return 1'b0;
      endcase
   endfunction : prefixOk

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   logic [3:0]       ctrl_q;
   albc_state_t      state_q;
   albc_req_t        req_q;
   logic             accept;
   logic             reqFault;
   logic             reqAtomic;
   logic             reqLocked;
   logic             reqCache;
   logic             needRead;
   logic             isFlagOp;
   logic             lastChunk;
   logic             chunk_q;
   logic             twoChunks_q;
   logic             useBusLock_q;
   logic             cacheLock_q;
   logic [127:0]     rdBuf_q;
   logic [63:0]      wrOp_q;
   logic [63:0]      operand;
   logic [63:0]      flagged;
   logic [127:0]     rdNext;
   logic [127:0]     wrWide;
   logic [15:0]      beWide;

   assign accept    = coreValid && coreReady && state_q == S_IDLE;
   assign reqAtomic = isAtomic(coreReq.addr, coreReq.sizeLog,
                               coreReq.cacheable);
   // Prefix on a wrong instruction or register target
   assign reqFault  = coreReq.kind == OP_LOCKED &&
                      (!prefixOk(coreReq.cls) || coreReq.destIsReg);

   // Operations that follow lock semantics
   always_comb begin
      case (coreReq.kind)
         OP_LOCKED,
         OP_SWAP,
         OP_TASK_BUSY,
         OP_SEG_ACC,
         OP_PAGE_AD,
         OP_INT_ACK:  reqLocked = 1'b1;
         default:     reqLocked = !reqAtomic && ctrl_q[CTRL_SPLIT_BIT];
      endcase
   end

   // Cache lock only when the whole operand sits in one line
   assign reqCache = coreReq.cacheable && ctrl_q[CTRL_CLOCK_BIT] &&
                     !ctrl_q[CTRL_ALWAYS_BIT] &&
                     inLine(coreReq.addr, coreReq.sizeLog);

   assign needRead  = req_q.kind != OP_STORE;
   assign isFlagOp  = req_q.kind == OP_TASK_BUSY ||
                      req_q.kind == OP_SEG_ACC ||
                      req_q.kind == OP_PAGE_AD;
   assign lastChunk = chunk_q == twoChunks_q;

   // Operand alignment within the two-word window
   assign rdNext   = chunk_q ? {memRdata, rdBuf_q[63:0]}
                             : {rdBuf_q[127:64], memRdata};
   assign operand  = 64'((rdNext >> {req_q.addr[2:0], 3'b000}) &
                         ((128'h1 << {nBytes(req_q.sizeLog), 3'b000}) -
                          128'h1));
   assign flagged  = operand | req_q.data;
   assign wrWide   = 128'(wrOp_q) << {req_q.addr[2:0], 3'b000};
   assign beWide   = {8'h00, 8'((9'h001 << nBytes(req_q.sizeLog)) - 9'h001)}
                     << req_q.addr[2:0];

   function automatic albc_mem_t memCycle(input logic w,
                                          input logic c);
      albc_mem_t m;
      m.valid     = 1'b1;
      m.write     = w;
      m.addr      = {req_q.addr[ADDR_W-1:3] + (ADDR_W-3)'(c), 3'b000};
      m.be        = c ? beWide[15:8] : beWide[7:0];
      m.wdata     = c ? wrWide[127:64] : wrWide[63:0];
      m.cacheLock = cacheLock_q;
      return m;
   endfunction : memCycle

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // One operation at a time; no new request until it ends
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q      <= S_IDLE;
         req_q        <= '0;
         chunk_q      <= 1'b0;
         twoChunks_q  <= 1'b0;
         useBusLock_q <= 1'b0;
         cacheLock_q  <= 1'b0;
         rdBuf_q      <= '0;
         wrOp_q       <= '0;
         memReq       <= '0;
         coreRsp      <= '0;
         coreReady    <= 1'b1;
         busLock      <= 1'b0;
      end else begin
         coreRsp.done   <= 1'b0;
         coreRsp.fault  <= 1'b0;
         coreRsp.modReq <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (accept && reqFault) begin
                  coreRsp.done  <= 1'b1;
                  coreRsp.fault <= 1'b1;
               end else if (accept) begin
                  req_q          <= coreReq;
                  wrOp_q         <= coreReq.data;
                  twoChunks_q    <= coreReq.kind != OP_INT_ACK &&
                                    spans(coreReq.addr, coreReq.sizeLog);
                  chunk_q        <= 1'b0;
                  useBusLock_q   <= reqLocked && !reqCache;
                  cacheLock_q    <= reqLocked && reqCache;
                  coreRsp.atomic <= reqAtomic || reqLocked;
                  coreReady      <= 1'b0;
                  busLock        <= reqLocked && !reqCache;
                  state_q        <= S_LOCK;
               end
            end
            S_LOCK: begin
               // Lock pin already high one cycle before the first cycle
               memReq  <= memCycle(req_q.kind == OP_STORE, 1'b0);
               state_q <= needRead ? S_READ : S_WRITE;
            end
            S_READ: begin
               if (memDone) begin
                  rdBuf_q <= rdNext;
                  if (!lastChunk) begin
                     chunk_q <= 1'b1;
                     memReq  <= memCycle(1'b0, 1'b1);
                  end else begin
                     chunk_q        <= 1'b0;
                     memReq         <= '0;
                     coreRsp.rdata  <= operand;
                     if (req_q.kind == OP_LOAD ||
                         req_q.kind == OP_INT_ACK) begin
                        state_q <= S_DONE;
                     end else if (isFlagOp) begin
                        wrOp_q <= flagged;
                        // Flag already set: newer flow skips write
                        if (req_q.kind == OP_SEG_ACC &&
                            ctrl_q[CTRL_SKIP_BIT] &&
                            flagged == operand) begin
                           state_q <= S_DONE;
                        end else begin
                           state_q <= S_MODIFY;
                        end
                     end else begin
                        coreRsp.modReq <= 1'b1;
                        state_q        <= S_MODIFY;
                     end
                  end
               end
            end
            S_MODIFY: begin
               // Flag ops proceed at once, instructions await core data
               if (isFlagOp || wrValid) begin
                  if (!isFlagOp) begin
                     wrOp_q <= wrData;
                  end
                  state_q <= S_WRITE;
               end
            end
            S_WRITE: begin
               if (!memReq.valid) begin
                  memReq <= memCycle(1'b1, chunk_q);
               end else if (memDone) begin
                  if (!lastChunk) begin
                     chunk_q <= 1'b1;
                     memReq  <= memCycle(1'b1, 1'b1);
                  end else begin
                     memReq  <= '0;
                     state_q <= S_DONE;
                  end
               end
            end
            S_DONE: begin
               // Release only after the final cycle finished
               busLock      <= 1'b0;
               useBusLock_q <= 1'b0;
               cacheLock_q  <= 1'b0;
               coreRsp.done <= 1'b1;
               coreReady    <= 1'b1;
               state_q      <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
               busLock <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Register slave
   // ------------------------------------------------------------
   logic              addrPhase;
   logic              wrPend_q;
   logic [REG_AW-1:0] wrAddr_q;
   logic              fcntClr;
   logic              lcntClr;
   logic [CNT_W-1:0]  faultCnt_q;
   logic [CNT_W-1:0]  lockCnt_q;
   logic [31:0]       statusWord;
   logic [31:0]       rdMux;

   assign addrPhase = hsel && htrans[1] && hready;
   assign fcntClr   = wrPend_q && wrAddr_q == FCNT_OFF;
   assign lcntClr   = wrPend_q && wrAddr_q == LCNT_OFF;

   always_comb begin
      statusWord = '0;
      statusWord[STAT_STATE_LSB +: 3] = state_q;
      statusWord[STAT_BUSY_BIT]       = state_q != S_IDLE;
      statusWord[STAT_BLOCK_BIT]      = useBusLock_q;
      statusWord[STAT_CLOCK_BIT]      = cacheLock_q;
   end

   always_comb begin
      case (haddr[REG_AW-1:0])
         CTRL_OFF: rdMux = {28'h0, ctrl_q};
         STAT_OFF: rdMux = statusWord;
         FCNT_OFF: rdMux = {16'h0, faultCnt_q};
         LCNT_OFF: rdMux = {16'h0, lockCnt_q};
         default:  rdMux = 32'h0;
      endcase
   end

   // Address phase capture, zero wait state, always OKAY
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wrPend_q  <= 1'b0;
         wrAddr_q  <= '0;
         hrdata    <= '0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wrPend_q <= addrPhase && hwrite;
         if (addrPhase) begin
            wrAddr_q <= haddr[REG_AW-1:0];
         end
         if (addrPhase && !hwrite) begin
            hrdata <= rdMux;
         end
      end
   end

   // Control register written in the data phase
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
      end else if (wrPend_q && wrAddr_q == CTRL_OFF) begin
         ctrl_q <= hwdata[3:0];
      end
   end

   // Event counters; a write clears, a same-cycle event wins
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         faultCnt_q <= '0;
         lockCnt_q  <= '0;
      end else begin
         if (accept && reqFault) begin
            faultCnt_q <= fcntClr ? CNT_W'(1) : faultCnt_q + CNT_W'(1);
         end else if (fcntClr) begin
            faultCnt_q <= '0;
         end
         if (accept && !reqFault && reqLocked) begin
            lockCnt_q <= lcntClr ? CNT_W'(1) : lockCnt_q + CNT_W'(1);
         end else if (lcntClr) begin
            lockCnt_q <= '0;
         end
      end
   end

endmodule : albc_lock_ctrl

// file: design/albc_pkg.sv
package albc_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0]  CTRL_OFF   = 8'h00;
   localparam logic [7:0]  STAT_OFF   = 8'h04;
   localparam logic [7:0]  FCNT_OFF   = 8'h08;
   localparam logic [7:0]  LCNT_OFF   = 8'h0C;
   localparam int          REG_AW     = 8;

   // Control fields
   localparam int          CTRL_CLOCK_BIT  = 0; // cache locking allowed
   localparam int          CTRL_SPLIT_BIT  = 1; // lock split plain access
   localparam int          CTRL_SKIP_BIT   = 2; // skip write, flag set
   localparam int          CTRL_ALWAYS_BIT = 3; // bus lock always used
   localparam logic [3:0]  CTRL_RESET      = 4'h7;

   // Status fields
   localparam int          STAT_STATE_LSB  = 0;
   localparam int          STAT_BUSY_BIT   = 4;
   localparam int          STAT_BLOCK_BIT  = 5;
   localparam int          STAT_CLOCK_BIT  = 6;

   // ------------------------------------------------------------
   // Data path
   // ------------------------------------------------------------
   localparam int          ADDR_W     = 32;
   localparam int          BUS_BYTES  = 8;
   localparam int          NARROW_BYTES = 4;
   localparam int          CNT_W      = 16;

   typedef enum logic [2:0] {
      OP_LOAD      = 3'h0,
      OP_STORE     = 3'h1,
      OP_LOCKED    = 3'h2,
      OP_SWAP      = 3'h3,
      OP_TASK_BUSY = 3'h4,
      OP_SEG_ACC   = 3'h5,
      OP_PAGE_AD   = 3'h6,
      OP_INT_ACK   = 3'h7
   } albc_op_t;

   typedef enum logic [3:0] {
      IC_BIT_TEST = 4'h0,
      IC_XADD     = 4'h1,
      IC_CMPXCHG  = 4'h2,
      IC_SWAP     = 4'h3,
      IC_INC      = 4'h4,
      IC_DEC      = 4'h5,
      IC_NOT      = 4'h6,
      IC_NEG      = 4'h7,
      IC_ALU2     = 4'h8,
      IC_OTHER    = 4'hF
   } albc_cls_t;

   typedef struct packed {
      albc_op_t          kind;
      albc_cls_t         cls;
      logic [1:0]        sizeLog;   // 0:1B 1:2B 2:4B 3:8B
      logic [ADDR_W-1:0] addr;
      logic              cacheable;
      logic              destIsReg;
      logic [63:0]       data;      // store data or flag mask
   } albc_req_t;

   typedef struct packed {
      logic              done;
      logic              fault;     // undefined_opcode_fault
      logic              atomic;
      logic              modReq;    // read done, modify data wanted
      logic [63:0]       rdata;
   } albc_rsp_t;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        be;
      logic [63:0]       wdata;
      logic              cacheLock;
   } albc_mem_t;

endpackage : albc_pkg

// file: tb/albc_lock_checker.sv
`timescale 1ns/1ps
module albc_lock_checker
   import albc_pkg::*;
(
   // Request valid, clock and reset
   input wire logic                coreValid,
   input wire logic                mclk,
   input wire logic                rst,
   // Core side
   input wire albc_pkg::albc_req_t coreReq,
   input wire logic                coreReady,
   input wire albc_pkg::albc_rsp_t coreRsp,
   // Memory side and lock
   input wire albc_pkg::albc_mem_t memReq,
   input wire logic                memDone,
   input wire logic                busLock
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (rst);
   logic take;
   logic badPfx;
   // Request acceptance and illegal prefix decode
   assign take   = coreValid && coreReady;
   assign badPfx = take && coreReq.kind == OP_LOCKED &&
                   (coreReq.cls > IC_ALU2 || coreReq.destIsReg);
   lock_first_a: assert property ($rose(busLock) |->
      !memReq.valid ##[1:2] (memReq.valid && !memReq.write))
      else $error("memory read did not follow lock");
   lock_hold_a: assert property (
      busLock && memReq.valid |=> busLock)
      else $error("lock dropped during memory cycle");
   lock_tail_a: assert property (
      $fell(busLock) |-> !memReq.valid && !$past(memReq.valid))
      else $error("lock dropped before final write ended");
   cache_only_a: assert property (
      memReq.cacheLock |-> !busLock)
      else $error("bus lock raised with cache lock");
   fault_pair_a: assert property (
      coreRsp.fault |-> coreRsp.done)
      else $error("fault without done");
   bad_prefix_a: assert property (
      badPfx |=> coreRsp.done && coreRsp.fault && !busLock)
      else $error("illegal prefix not faulted");
   swap_lock_a: assert property (
      take && coreReq.kind == OP_SWAP && !coreReq.cacheable
      |-> ##[1:2] busLock)
      else $error("swap ran without bus lock");
   auto_lock_a: assert property (
      take && !coreReq.cacheable &&
      coreReq.kind inside {OP_TASK_BUSY, OP_PAGE_AD, OP_INT_ACK}
      |-> ##[1:2] busLock)
      else $error("system update ran without bus lock");
   req_hold_a: assert property (
      memReq.valid && !memDone |=> memReq.valid && $stable(memReq.addr))
      else $error("memory request changed before done");
   cov_lock: cover property ($rose(busLock));
   cov_cache: cover property (memReq.valid && memReq.cacheLock);
   cov_fault: cover property (coreRsp.fault);
endmodule : albc_lock_checker

bind albc_lock_ctrl albc_lock_checker u_chk (.mclk, .rst, .coreValid,
   .coreReq, .coreReady, .coreRsp, .memReq, .memDone, .busLock);

// file: tb/albc_mem_model.sv
`timescale 1ns/1ps
module albc_mem_model
   import albc_pkg::*;
(
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                rst,
   // Memory port
   input  wire albc_pkg::albc_mem_t memReq,
   output logic                     memDone,
   output logic [63:0]              memRdata
);
   logic [63:0] mem [32];
   logic [1:0]  waitQ;
   logic [1:0]  dlyQ;
   // Known start pattern, distinct bytes per word
   initial begin
      for (int i = 0; i < 32; i++) mem[i] = {8{i[7:0]}} ^ 64'h0706050403020100;
   end
   // Answer after a varying wait, scramble data when idle
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         memDone  <= 1'b0;
         memRdata <= 64'h0;
         waitQ    <= 2'h0;
         dlyQ     <= 2'h0;
      end else if (memReq.valid && !memDone && waitQ == 2'h0) begin
         memDone  <= 1'b1;
         memRdata <= mem[memReq.addr[7:3]];
         dlyQ     <= dlyQ + 2'h1;
         if (memReq.write) for (int b = 0; b < 8; b++) if (memReq.be[b])
            mem[memReq.addr[7:3]][8*b+:8] <= memReq.wdata[8*b+:8];
      end else begin
         memDone  <= 1'b0;
         memRdata <= ~memRdata;
         waitQ    <= memReq.valid && !memDone ? waitQ - 2'h1 : dlyQ;
      end
   end
endmodule : albc_mem_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import albc_pkg::*;
   typedef struct packed {
      logic [63:0] rdata;
      logic        useData;
      logic        fault;
      logic        atomic;
      logic [1:0]  lock; // 2 means either
   } albc_note_t;
   logic        mclk, rst, hsel, hwrite, hreadyout, hresp, coreValid;
   logic        coreReady, wrValid, memDone, busLock, sawLock;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [63:0] wrData, memRdata, nextWr, prev;
   albc_req_t   coreReq;
   albc_rsp_t   coreRsp;
   albc_mem_t   memReq;
   int          n_fail, n_checks, nDone, seed;
   albc_note_t  notes[$];

   albc_lock_ctrl #(.LINE_BYTES(64)) u_dut (.mclk, .rst, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .coreValid, .coreReq, .coreReady, .coreRsp,
      .wrValid, .wrData, .memReq, .memDone, .memRdata, .busLock);
   albc_mem_model u_mem (.mclk, .rst, .memReq, .memDone, .memRdata);

   // Clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   function automatic logic [63:0] initw(input int i);
      return {8{i[7:0]}} ^ 64'h0706050403020100;
   endfunction : initw
   // Expected right-aligned load value from start pattern
   function automatic logic [63:0] expLd(input logic [31:0] a,
                                         input logic [1:0] s);
      logic [127:0] w;
      w = {initw(a[7:3] + 1), initw(a[7:3])} >> (8 * a[2:0]);
      return 64'(w & ((128'h1 << (8 << s)) - 128'h1));
   endfunction : expLd
   // Atomic by size, alignment and caching
   function automatic logic expAt(input logic [31:0] a, input logic [1:0] s,
                                  input logic ca);
      int n;
      n = 1 << s;
      if (a % n == 0) return 1'b1;
      if (s == 2'h1 && !ca && a[1:0] != 2'h3) return 1'b1;
      return ca && (a % 64) + n <= 64;
   endfunction : expAt

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   task automatic tmo;
      n_fail++;
      complete_run();
   endtask : tmo

   // AHB-Lite single word transfer
   task automatic ahb(input logic wr, input logic [31:0] a, d, exp);
      int k;
      k = 0;
      hwrite <= wr;
      haddr  <= a;
      htrans <= 2'h2;
      do begin @(posedge mclk); k++; end while (hreadyout !== 1'b1 && k < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge mclk); k++; end while (hreadyout !== 1'b1 && k < 99);
      if (k >= 99) tmo();
      chk(64'(hresp), 64'h0);
      if (!wr) chk(64'(hrdata), 64'(exp));
   endtask : ahb

   // Core request with its expected outcome noted
   task automatic op(input albc_op_t kd, input albc_cls_t c,
                     input logic [1:0] s, input logic [31:0] a,
                     input logic ca, dr, input logic [63:0] d, er,
                     input logic ue, ef, ea, input logic [1:0] el);
      int k;
      int base;
      k = 0;
      base = nDone;
      notes.push_back('{er, ue, ef, ea, el});
      coreReq   <= '{kd, c, s, a, ca, dr, d};
      coreValid <= 1'b1;
      do begin @(posedge mclk); k++; end while (coreReady !== 1'b1 && k < 50);
      coreValid <= 1'b0;
      while (nDone == base && k < 300) begin @(posedge mclk); k++; end
      if (k >= 300) tmo();
   endtask : op

   // Core modify data after the read of each locked instruction or swap
   always @(posedge mclk) begin
      wrValid <= coreRsp.modReq === 1'b1;
      wrData  <= nextWr;
   end
   // Result monitor against oldest note
   always @(posedge mclk) begin : mon
      albc_note_t n;
      if (rst === 1'b1) sawLock = 1'b0;
      if (busLock === 1'b1) sawLock = 1'b1;
      if (coreRsp.done === 1'b1 && notes.size() > 0) begin
         n = notes.pop_front();
         chk(coreRsp.fault, n.fault);
         if (!n.fault) chk(coreRsp.atomic, n.atomic);
         if (n.useData) chk(coreRsp.rdata, n.rdata);
         if (n.lock != 2'h2) chk(sawLock, n.lock[0]);
         sawLock = 1'b0;
         nDone <= nDone + 1;
      end
   end

   // Main sequence
   initial begin
      logic [1:0]  s;
      logic [31:0] a;
      logic        ca;
      seed = 62;
      {n_fail, n_checks} = '0;
      {rst, hsel, hwrite, coreValid} = 4'hC;
      {htrans, hsize, haddr, hwdata, coreReq, nextWr} = '0;
      hsize = 3'h2;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      ahb(0, CTRL_OFF, 0, 32'h7);
      ahb(0, 32'h40, 0, 0);
      op(OP_LOAD, IC_OTHER, 2, 6, 0, 0, 0, expLd(6, 2), 1, 0, 1, 1);
      ahb(1, CTRL_OFF, 32'h5, 0);
      ahb(0, CTRL_OFF, 0, 32'h5);
      for (int i = 0; i < 28; i++) begin
         s  = 2'($random(seed));
         a  = 32'($unsigned($random(seed))) % 120;
         ca = 1'($random(seed));
         op(OP_LOAD, IC_OTHER, s, a, ca, 0, 0, expLd(a, s), 1, 0,
            expAt(a, s, ca), 0);
      end
      op(OP_LOAD, IC_OTHER, 3, 57, 1, 0, 0, expLd(57, 3), 1, 0, 0, 0);
      op(OP_LOAD, IC_OTHER, 1, 3, 0, 0, 0, expLd(3, 1), 1, 0, 0, 0);
      for (int k = 0; k <= 9; k++) begin
         if (k == 9) ahb(1, CTRL_OFF, 32'hF, 0);
         prev   = (k == 0) ? initw(16) : nextWr;
         nextWr = {$random(seed), $random(seed)};
         op(OP_LOCKED, albc_cls_t'(k % 9), 3, 128, k[0], 0, 0, prev, 1, 0, 1,
            {1'b0, !k[0] || k == 9});
      end
      op(OP_LOAD, IC_OTHER, 3, 128, 0, 0, 0, nextWr, 1, 0, 1, 0);
      op(OP_LOCKED, IC_OTHER, 2, 128, 0, 0, 0, 0, 0, 1, 0, 0);
      op(OP_LOCKED, IC_INC, 2, 128, 0, 1, 0, 0, 0, 1, 0, 0);
      ahb(0, FCNT_OFF, 0, 32'h2);
      op(OP_SWAP, IC_SWAP, 3, 136, 0, 0, 0, initw(17), 1, 0, 1, 1);
      op(OP_TASK_BUSY, IC_OTHER, 3, 144, 0, 0, 64'h200, initw(18), 1, 0, 1, 1);
      op(OP_LOAD, IC_OTHER, 3, 144, 0, 0, 0, initw(18) | 64'h200, 1, 0, 1, 0);
      op(OP_PAGE_AD, IC_OTHER, 3, 152, 0, 0, 64'h60, initw(19), 1, 0, 1, 1);
      op(OP_INT_ACK, IC_OTHER, 3, 160, 0, 0, 0, initw(20), 1, 0, 1, 1);
      op(OP_SEG_ACC, IC_OTHER, 3, 168, 0, 0, 64'h100, initw(21), 1, 0, 1, 1);
      op(OP_SEG_ACC, IC_OTHER, 3, 168, 0, 0, 64'h100, initw(21) | 64'h100,
         1, 0, 1, 2);
      op(OP_STORE, IC_OTHER, 3, 176, 0, 0, nextWr, 0, 0, 0, 1, 0);
      op(OP_LOAD, IC_OTHER, 3, 176, 0, 0, 0, nextWr, 1, 0, 1, 0);
      // Descriptor update bracket: locked mark, plain write, locked mark
      nextWr = 64'h80;
      op(OP_LOCKED, IC_NOT, 0, 184, 0, 0, 0, 64'h17, 1, 0, 1, 1);
      op(OP_STORE, IC_OTHER, 0, 185, 0, 0, 64'h5, 0, 0, 0, 1, 0);
      op(OP_LOCKED, IC_NOT, 0, 184, 0, 0, 0, 64'h80, 1, 0, 1, 1);
      op(OP_LOAD, IC_OTHER, 0, 185, 0, 0, 0, 64'h5, 1, 0, 1, 0);
      // Locked operation count, then clear by write
      ahb(0, LCNT_OFF, 0, 32'h13);
      ahb(1, LCNT_OFF, 0, 0);
      ahb(0, LCNT_OFF, 0, 0);
      complete_run();
   end
endmodule : tb_top
